//--- logic/vic_top.sv
/*
  Vectored interrupt controller: merges 8 traps and 118 maskable
  sources into one request to the core, supplies the handler address
  from the vector table, APB register slave, sticky event interrupt.
  Assumes sources and core signals are on the same clock.
*/
// The implementer's own choices: the placing of the registers and the APB register port.
// Behaviour
// - all sources merge into one core request
// - table holds 8 traps plus 118 sources
// - every source owns its own table slot
// - seven software-selectable priority levels
// - equal level resolved by fixed order
// - lower slot wins, slot zero beats all
// - table entries start at word 000004h
// - entry is the 24-bit handler address
// - entry and return latency fixed
// - reset bypasses controller, address zero
// - enable word 1 bits 13, 4..0 external
`timescale 1ns/1ns
`default_nettype none
`include "vic_map.svh"
module vic_top (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic [7:0]        trap_req,
  input  wire logic [117:0]      irq_src,
  input  wire vic_pkg::vic_lvl_t cpu_ipl,
  input  wire logic              irq_ack,
  input  wire logic              irq_ret,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   cpu_irq_req,
  output var vic_pkg::vic_addr_t cpu_irq_vec,
  output var vic_pkg::vic_lvl_t  cpu_irq_lvl,
  output var vic_pkg::vic_idx_t  cpu_irq_idx,
  output var vic_pkg::vic_addr_t vt_entry_addr,
  output logic                   irq_out
);
  import vic_pkg::*;

  logic [1:0]        rs_r;
  logic              rst_n;
  logic [7:0][15:0]  en_r, en_nxt;
  logic [29:0][15:0] prio_r, prio_nxt;
  logic [127:0]      en_flat;
  logic [2:0]        stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic [31:0]       prdata_r, prdata_nxt;
  vic_state_t        st_r, st_nxt;
  vic_idx_t          widx_r, widx_nxt, win_idx;
  vic_lvl_t          wlvl_r, wlvl_nxt, win_lvl;
  vic_addr_t         vec_r, vec_nxt, ent_r, ent_nxt;
  logic [1:0]        cnt_r, cnt_nxt;
  logic              win_vld, go;
  logic [125:0]      req;
  logic [503:0]      lvl_flat;
  logic              aligned, en_hit, prio_hit, vt_hit, hit, wr, rd;
  logic [2:0]        en_sel;
  logic [4:0]        prio_sel;
  logic [6:0]        vt_sel;

  vic_vt_if vt ();

  // reset release through two flops; the assertion side stays async
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rs_r <= 2'h0;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];

  // apb decode; the slave never stalls
  always_comb begin
    aligned  = (paddr[1:0] == 2'h0);
    en_hit   = (paddr <= `VIC_EN_LAST);
    en_sel   = paddr[4:2];
    prio_hit = (paddr >= `VIC_PRIO_BASE) && (paddr <= `VIC_PRIO_LAST);
    prio_sel = 5'((paddr - `VIC_PRIO_BASE) >> 2);
    vt_hit   = (paddr >= `VIC_VT_BASE) && (paddr <= `VIC_VT_LAST);
    vt_sel   = 7'((paddr - `VIC_VT_BASE) >> 2);
    hit      = aligned && (en_hit || prio_hit || vt_hit || paddr == `VIC_STAT
               || paddr == `VIC_MASK || paddr == `VIC_STATE);
    wr       = psel && penable && pwrite && hit;
    rd       = psel && !penable && !pwrite;
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // software-written configuration: enables, levels, event mask
  always_comb begin
    en_nxt   = en_r;
    prio_nxt = prio_r;
    mask_nxt = mask_r;
    if (wr && en_hit) begin
      unique case (en_sel)
        3'h1:    en_nxt[en_sel] = pwdata[15:0] & `VIC_INTERRUPT_ENABLE_CONTROL_1_MASK;
        3'h7:    en_nxt[en_sel] = pwdata[15:0] & `VIC_EN7_MASK;
        default: en_nxt[en_sel] = pwdata[15:0];
      endcase
    end
    // three bits per source give levels 1..7, level 0 parks it
    if (wr && prio_hit) begin
      prio_nxt[prio_sel] = pwdata[15:0] &
        ((prio_sel == 5'h1D) ? `VIC_PRIO29_MASK : `VIC_PRIO_MASK);
    end
    if (wr && paddr == `VIC_MASK) begin
      mask_nxt = pwdata[2:0];
    end
  end
  assign en_flat = en_r;

  // read mux, loaded in the setup cycle so prdata comes from a flop
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd) begin
      prdata_nxt = 32'h0;
      if (aligned && en_hit) begin
        prdata_nxt[15:0] = en_r[en_sel];
      end else if (aligned && prio_hit) begin
        prdata_nxt[15:0] = prio_r[prio_sel];
      end else if (paddr == `VIC_STAT) begin
        prdata_nxt[2:0] = stat_r;
      end else if (paddr == `VIC_MASK) begin
        prdata_nxt[2:0] = mask_r;
      end else if (paddr == `VIC_STATE) begin
        prdata_nxt[16:0] = {st_r, wlvl_r, widx_r};
      end
    end
  end

  // slot map: traps own slots 0..7, source s owns slot 8+s
  for (genvar g = 0; g < `VIC_N_VEC; g++) begin : g_slot
    if (g < `VIC_N_TRAP) begin : g_trap
      assign req[g]            = trap_req[g];
      assign lvl_flat[g*4 +: 4] = `VIC_TRAP_LVL;
    end else begin : g_irq
      logic [2:0] lvl;
      assign lvl                = prio_r[(g-8)/4][((g-8)%4)*4 +: 3];
      assign lvl_flat[g*4 +: 4] = {1'b0, lvl};
      assign req[g] = irq_src[g-8] && en_flat[g-8] && (lvl != 3'h0);
    end
  end

  vic_prio_enc u_enc (
    .req      (req),
    .lvl_flat (lvl_flat),
    .win_idx  (win_idx),
    .win_lvl  (win_lvl),
    .win_vld  (win_vld)
  );

  // table port: controller reads, apb writes
  assign vt.rd_idx  = widx_r;
  assign vt.wr_en   = wr && vt_hit;
  assign vt.wr_idx  = vt_sel;
  assign vt.wr_data = pwdata[23:0];

  vic_vt_mem u_vt (
    .clock (clock),
    .vt    (vt)
  );

  // one merged request, only above the core's current level
  assign go = win_vld && (win_lvl > cpu_ipl);

  // entry: idle, look, fetch, offer is always three cycles; no preemption
  always_comb begin
    st_nxt   = st_r;
    widx_nxt = widx_r;
    wlvl_nxt = wlvl_r;
    vec_nxt  = vec_r;
    ent_nxt  = ent_r;
    cnt_nxt  = cnt_r;
    ev       = 3'h0;
    unique case (st_r)
      VIC_IDLE: begin
        if (go) begin
          st_nxt   = VIC_LOOK;
          widx_nxt = win_idx;
          wlvl_nxt = win_lvl;
        end
      end
      VIC_LOOK: begin
        st_nxt  = VIC_FETCH;
        ent_nxt = `VIC_VT_ORG + widx_r;
      end
      VIC_FETCH: begin
        st_nxt  = VIC_OFFER;
        vec_nxt = vt.rd_data;
      end
      VIC_OFFER: begin
        if (irq_ack) begin
          st_nxt              = VIC_SERVE;
          ev[`VIC_EV_ENTRY] = 1'b1;
          ev[`VIC_EV_TRAP]  = (widx_r < 7'h08);
        end
      end
      VIC_SERVE: begin
        if (irq_ret) begin
          st_nxt  = VIC_RETURN;
          cnt_nxt = `VIC_RET_LAST;
        end
      end
      VIC_RETURN: begin
        if (cnt_r == 2'h0) begin
          st_nxt          = VIC_IDLE;
          ev[`VIC_EV_RET] = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
    endcase
  end

  // sticky events: a set in the clearing cycle survives
  always_comb begin
    stat_nxt = stat_r & ~((wr && paddr == `VIC_STAT) ? pwdata[2:0] : 3'h0);
    stat_nxt = stat_nxt | ev;
  end
  assign irq_out = |(stat_r & mask_r);

  // state registers; reset leaves the core at address zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_r     <= '0;
      prio_r   <= '0;
      mask_r   <= 3'h0;
      stat_r   <= 3'h0;
      prdata_r <= 32'h0;
      st_r     <= VIC_IDLE;
      widx_r   <= 7'h00;
      wlvl_r   <= 4'h0;
      vec_r    <= `VIC_RESET_PC;
      ent_r    <= `VIC_RESET_PC;
      cnt_r    <= 2'h0;
    end else begin
      en_r     <= en_nxt;
      prio_r   <= prio_nxt;
      mask_r   <= mask_nxt;
      stat_r   <= stat_nxt;
      prdata_r <= prdata_nxt;
      st_r     <= st_nxt;
      widx_r   <= widx_nxt;
      wlvl_r   <= wlvl_nxt;
      vec_r    <= vec_nxt;
      ent_r    <= ent_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  assign prdata        = prdata_r;
  assign cpu_irq_req   = (st_r == VIC_OFFER);
  assign cpu_irq_vec   = vec_r;
  assign cpu_irq_lvl   = wlvl_r;
  assign cpu_irq_idx   = widx_r;
  assign vt_entry_addr = ent_r;

  // checker helper: any pending slot that should have beaten the winner
  logic beaten;
  always_comb begin
    beaten = 1'b0;
    for (int i = 0; i < `VIC_N_VEC; i++) begin
      if (req[i] && (lvl_flat[i*4 +: 4] > win_lvl
          || (lvl_flat[i*4 +: 4] == win_lvl && 7'(i) < win_idx))) begin
        beaten = 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  entry_latency_a: assert property ((st_r == VIC_IDLE && go) |=>
    !cpu_irq_req ##1 !cpu_irq_req ##1 (cpu_irq_req && cpu_irq_idx == $past(win_idx, 3)))
    else $error("entry latency not three cycles");
  vector_pick_a: assert property ((st_r == VIC_FETCH) |=>
    (cpu_irq_vec == $past(vt.rd_data)) && cpu_irq_req)
    else $error("offered vector differs from table word");
  rank_order_a: assert property (win_vld |-> !beaten)
    else $error("winner outranked by pending slot");
  trap_zero_a: assert property ((trap_req[0] && st_r == VIC_IDLE && cpu_ipl < 4'h8)
    |=> (st_r == VIC_LOOK && widx_r == 7'h00))
    else $error("slot zero did not win");
  mask_gate_a: assert property ((trap_req == 8'h00 && (irq_src & en_flat[117:0]) == '0)
    |-> !win_vld)
    else $error("disabled source reached the encoder");
  return_time_a: assert property ((st_r == VIC_SERVE && irq_ret)
    |=> (st_r == VIC_RETURN) [*2] ##1 (st_r == VIC_IDLE && stat_r[`VIC_EV_RET]))
    else $error("return latency not two cycles");
  ext_enable_a: assert property ((wr && paddr == 12'h004) |=>
    en_r[1] == ($past(pwdata[15:0]) & 16'h201F))
    else $error("enable word 1 layout wrong");
  table_origin_a: assert property ((st_r == VIC_FETCH) |->
    vt_entry_addr == 24'h000004 + {17'h0, widx_r})
    else $error("table slot address wrong");
  reset_start_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(rst_n) |-> (cpu_irq_vec == 24'h000000 && !cpu_irq_req))
    else $error("reset did not start at zero");
  event_sticky_a: assert property ((st_r == VIC_OFFER && irq_ack) |=>
    stat_r[`VIC_EV_ENTRY] [*2])
    else $error("entry event lost");

  trap_taken_c:  cover property (st_r == VIC_OFFER && irq_ack && widx_r < 7'h08);
  top_level_c:   cover property (st_r == VIC_OFFER && irq_ack && wlvl_r == 4'h7);
  return_done_c: cover property (stat_r[`VIC_EV_RET] && irq_out);
  bad_access_c:  cover property (pslverr);
endmodule : vic_top
`default_nettype wire

//--- logic/vic_map.svh
/*
  Register offsets, field masks, reset values and fixed latencies of the
  vectored interrupt controller. Assumes a 12-bit APB byte address.
*/
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH
// apb byte offsets
`define VIC_EN_LAST     12'h01C
`define VIC_PRIO_BASE   12'h040
`define VIC_PRIO_LAST   12'h0B4
`define VIC_STAT        12'h100
`define VIC_MASK        12'h104
`define VIC_STATE       12'h108
`define VIC_VT_BASE     12'h200
`define VIC_VT_LAST     12'h3F4
// enable word write masks: word 1 has only bits 13, 4..0
`define VIC_INTERRUPT_ENABLE_CONTROL_1_MASK   16'h201F
`define VIC_EN7_MASK    16'h003F
`define VIC_PRIO_MASK   16'h7777
`define VIC_PRIO29_MASK 16'h0077
// table geometry and addresses
`define VIC_N_TRAP      8
`define VIC_N_IRQ       118
`define VIC_N_VEC       126
`define VIC_VT_ORG      24'h000004
`define VIC_RESET_PC    24'h000000
`define VIC_TRAP_LVL    4'h8
// status bit positions
`define VIC_EV_ENTRY    0
`define VIC_EV_TRAP     1
`define VIC_EV_RET      2
// return latency in cycles, minus one
`define VIC_RET_LAST    2'h1
`endif

//--- logic/vic_pkg.sv
/*
  Types of the vectored interrupt controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package vic_pkg;
  typedef logic [23:0] vic_addr_t;
  typedef logic [6:0]  vic_idx_t;
  typedef logic [3:0]  vic_lvl_t;
  typedef enum logic [5:0] {
    VIC_IDLE   = 6'h01,
    VIC_LOOK   = 6'h02,
    VIC_FETCH  = 6'h04,
    VIC_OFFER  = 6'h08,
    VIC_SERVE  = 6'h10,
    VIC_RETURN = 6'h20
  } vic_state_t;
endpackage : vic_pkg
`default_nettype wire

//--- logic/vic_vt_if.sv
/*
  Carrier between the controller and its vector table memory.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface vic_vt_if;
  logic [6:0]  rd_idx;
  logic [23:0] rd_data;
  logic        wr_en;
  logic [6:0]  wr_idx;
  logic [23:0] wr_data;
  modport ctl (output rd_idx, output wr_en, output wr_idx, output wr_data, input rd_data);
  modport mem (input rd_idx, input wr_en, input wr_idx, input wr_data, output rd_data);
endinterface : vic_vt_if
`default_nettype wire

//--- logic/vic_vt_mem.sv
/*
  Vector table store: 126 handler addresses of 24 bits, one write port,
  one read port whose data come out of a register one cycle later.
  Assumes the writer keeps indices below 126.
*/
`timescale 1ns/1ns
`default_nettype none
`include "vic_map.svh"
module vic_vt_mem (
  input wire logic clock,
  vic_vt_if.mem    vt
);
  logic [23:0] mem_r [`VIC_N_VEC];
  logic [23:0] rd_r;

  // contents are software loaded, so no reset on the array
  always_ff @(posedge clock) begin
    if (vt.wr_en) begin
      mem_r[vt.wr_idx] <= vt.wr_data;
    end
    rd_r <= mem_r[vt.rd_idx];
  end

  assign vt.rd_data = rd_r;
endmodule : vic_vt_mem
`default_nettype wire

//--- logic/vic_prio_enc.sv
/*
  Winner search over all 126 vector slots: highest level first, then
  the lowest slot. Purely combinational.
  Assumes unused or disabled slots arrive with their request low.
*/
`timescale 1ns/1ns
`default_nettype none
module vic_prio_enc (
  input  wire logic [125:0]  req,
  input  wire logic [503:0]  lvl_flat,
  output var vic_pkg::vic_idx_t win_idx,
  output var vic_pkg::vic_lvl_t win_lvl,
  output logic               win_vld
);
  import vic_pkg::*;

  // walk downward so that on equal level the lower slot is taken last
  always_comb begin
    win_idx = '0;
    win_lvl = '0;
    win_vld = 1'b0;
    for (int i = 125; i >= 0; i--) begin
      if (req[i] && (lvl_flat[i*4 +: 4] >= win_lvl)) begin
        win_vld = 1'b1;
        win_lvl = lvl_flat[i*4 +: 4];
        win_idx = 7'(i);
      end
    end
  end
endmodule : vic_prio_enc
`default_nettype wire

//--- testbench/vic_core_model.sv
/*
  Core-side model: takes an offered interrupt after a set delay and
  ends the handler after the same delay.
  Assumes it shares the controller's clock.
*/
`timescale 1ns/1ns
`default_nettype none
module vic_core_model (
  input  wire logic       clock,
  input  wire logic       cpu_irq_req,
  input  wire logic [2:0] dly,
  output logic            irq_ack,
  output logic            irq_ret
);
  logic [1:0] ph;
  logic [2:0] cnt;
  initial begin
    ph = 2'h0;
    cnt = 3'h0;
    irq_ack = 1'b0;
    irq_ret = 1'b0;
  end
  // one-cycle pulses; delay 0 answers as soon as the core may
  always @(posedge clock) begin
    irq_ack <= 1'b0;
    irq_ret <= 1'b0;
    if (cnt != 3'h0) cnt <= cnt - 3'h1;
    if (ph == 2'h0 && !cpu_irq_req) cnt <= dly;
    else if (ph == 2'h0 && cnt == 3'h0) begin
      irq_ack <= 1'b1;
      ph <= 2'h1;
      cnt <= dly;
    end else if (ph == 2'h1 && cnt == 3'h0) begin
      irq_ret <= 1'b1;
      ph <= 2'h2;
    end else if (ph == 2'h2) ph <= 2'h0; // no second ack on a stale request
  end
endmodule : vic_core_model
`default_nettype wire

//--- testbench/test_vectored_interrupt_controller.sv
/*
  Self-checking bench of the controller: APB master, sources, core model.
  Assumes the controller files and the core model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "vic_map.svh"
module test_vectored_interrupt_controller;
  import vic_pkg::*;
  logic             clock, arst_n, irq_ack, irq_ret, psel, penable, pwrite;
  logic             pready, pslverr, cpu_irq_req, irq_out, err;
  logic [7:0]       trap_req;
  logic [117:0]     irq_src;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd, d;
  logic [2:0]       dly;
  logic [2:0]       lv [118];
  vic_lvl_t         cpu_ipl, cpu_irq_lvl;
  vic_addr_t        cpu_irq_vec, vt_entry_addr;
  vic_idx_t         cpu_irq_idx, ei;
  int               miscompares, n_tests, seed, k, w, j;

  vic_top DUT (.clock(clock), .arst_n(arst_n), .trap_req(trap_req), .irq_src(irq_src),
    .cpu_ipl(cpu_ipl), .irq_ack(irq_ack), .irq_ret(irq_ret), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_vec(cpu_irq_vec), .cpu_irq_lvl(cpu_irq_lvl), .cpu_irq_idx(cpu_irq_idx),
    .vt_entry_addr(vt_entry_addr), .irq_out(irq_out));
  vic_core_model core (.clock(clock), .cpu_irq_req(cpu_irq_req), .dly(dly),
    .irq_ack(irq_ack), .irq_ret(irq_ret));

  // 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // handler address per slot, all distinct
  function automatic vic_addr_t vexp(input int s);
    return 24'h300000 ^ 24'(s * 24'h010203);
  endfunction : vexp
  // only word 1 has unwritable enables of existing sources
  function automatic logic enb(input int s);
    logic [15:0] m;
    m = `VIC_INTERRUPT_ENABLE_CONTROL_1_MASK;
    return (s / 16 != 1) || m[s % 16];
  endfunction : enb

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // waits for pready however long it takes; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic trial(input logic [7:0] t, input logic [117:0] s, input vic_lvl_t ipl,
                       input logic [31:0] m);
    int bl;
    bl = 0;
    ei = 7'h00;
    for (int q = 0; q < 8; q++) if (t[q] && bl < 8) begin
      bl = 8;
      ei = 7'(q);
    end
    for (int q = 0; q < 118; q++) if (s[q] && enb(q) && lv[q] > bl) begin
      bl = lv[q];
      ei = 7'(q + 8);
    end
    apb(1'b1, `VIC_MASK, m);
    @(posedge clock);
    trap_req <= t;
    irq_src <= s;
    cpu_ipl <= ipl;
    if (bl <= ipl) begin
      repeat (8) @(posedge clock);
      #1 chk(cpu_irq_req, 0);
    end else begin
      // taken at the next edge, then look and fetch: offer shows after the third
      repeat (2) @(posedge clock);
      #1 chk(cpu_irq_req, 0);
      @(posedge clock);
      #1 chk(cpu_irq_req, 1);
      chk(cpu_irq_idx, ei);
      chk(cpu_irq_lvl, bl);
      chk(cpu_irq_vec, vexp(ei));
      chk(vt_entry_addr, `VIC_VT_ORG + ei);
    end
    @(posedge clock);
    trap_req <= 8'h00;
    irq_src <= '0;
    cpu_ipl <= 4'h0;
    if (bl > ipl) begin
      k = 0;
      do begin
        apb(1'b0, `VIC_STATE, 32'h0);
        k++;
      end while (rd[16:11] !== 6'h01 && k < 20);
      chk(rd[16:11], 6'h01);
      apb(1'b0, `VIC_STAT, 32'h0);
      chk(rd, (ei < 8) ? 32'h7 : 32'h5);
      #1 chk(irq_out, m != 0);
      apb(1'b1, `VIC_STAT, 32'h7);
      apb(1'b0, `VIC_STAT, 32'h0);
      chk(rd, 0);
      #1 chk(irq_out, 0);
    end
  endtask : trial

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end

  // main sequence: reset, registers, table, corner cases, random traffic
  initial begin
    {arst_n, psel, penable, pwrite, trap_req, irq_src, cpu_ipl} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dly = 3'h0;
    miscompares = 0;
    n_tests = 0;
    seed = 36;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk(cpu_irq_req, 0);
    chk(cpu_irq_vec, `VIC_RESET_PC);
    chk(irq_out, 0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 0);
    apb(1'b1, 12'h004, 32'hFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h201F);
    apb(1'b0, 12'h030, 32'h0);
    chk(err, 1);
    for (k = 0; k < 8; k++) apb(1'b1, 12'(4 * k), 32'hFFFF);
    for (k = 0; k < 118; k++) lv[k] = 3'(1 + $unsigned($random(seed)) % 7);
    for (w = 0; w < 30; w++) begin
      d = 32'h0;
      for (j = 0; j < 4; j++) if (4 * w + j < 118) d[4 * j +: 3] = lv[4 * w + j];
      apb(1'b1, `VIC_PRIO_BASE + 12'(4 * w), d);
    end
    for (k = 0; k < 126; k++) apb(1'b1, `VIC_VT_BASE + 12'(4 * k), 32'(vexp(k)));
    apb(1'b0, `VIC_VT_BASE, 32'h0);
    chk(rd, 0);
    trial(8'h01, '1, 4'h0, 32'h7);
    trial(8'h00, 118'(1) << 21, 4'h0, 32'h7);
    trial(8'h00, 118'(1) << 29, 4'h0, 32'h0);
    trial(8'h80, '1, 4'h7, 32'h7);
    trial(8'h00, '1, 4'h7, 32'h0);
    // sparse random sources, random core level and response delay
    for (w = 0; w < 30; w++) begin
      @(posedge clock);
      dly <= 3'($random(seed));
      trial(8'($random(seed)) & 8'($random(seed)) & 8'($random(seed)),
            118'({$random(seed), $random(seed), $random(seed), $random(seed)}) &
            118'({$random(seed), $random(seed), $random(seed), $random(seed)}),
            4'($unsigned($random(seed)) % 4), (w % 2 != 0) ? 32'h7 : 32'h0);
    end
    conclude();
  end
endmodule : test_vectored_interrupt_controller
`default_nettype wire
